// >>> dv/cu_event_status_properties.sv
// bus, line-side and flag properties of the copper event block
`timescale 1ns/1ns
module cu_event_checker (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic [3:0] tx_pair_data,
  input wire logic [3:0] media_pair_lines,
  input wire logic short_gap_seen,
  input wire logic gap_link_drop,
  input wire logic global_irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [3:0] tx_q;
  logic [3:0] inv_now;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_q <= 4'h0;
    end else begin
      tx_q <= tx_pair_data;
    end
  end
  // inversion pattern only moves after a control write
  assign inv_now = media_pair_lines ^ tx_q;
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_req_answered: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
    |=> wb_ack_o || wb_err_o) else $error("request not answered");
  a_no_idle_ack: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o && !wb_err_o)
    else $error("answer without request");
  a_one_answer: assert property (!(wb_ack_o && wb_err_o))
    else $error("ack and err together");
  a_rdata_hold: assert property (!wb_ack_o |-> $stable(wb_dat_o))
    else $error("read data moved without ack");
  a_pol_steady: assert property (!$past(wb_ack_o) |-> $stable(inv_now))
    else $error("pair inversion moved without write");
  a_gap_quiet: assert property (!short_gap_seen [*4] |=> !gap_link_drop)
    else $error("link drop without short gap");
  a_irq_clear_cause: assert property ($fell(global_irq)
    |-> $past(wb_ack_o) || $past(wb_ack_o, 2)) else $error("flag fell without access");
  c_err: cover property (wb_err_o);
  c_irq: cover property ($rose(global_irq));
  c_drop: cover property (gap_link_drop);
endmodule : cu_event_checker

bind cu_event_status cu_event_checker i_chk (.sys_clk, .rst, .wb_cyc_i, .wb_stb_i,
  .wb_dat_o, .wb_ack_o, .wb_err_o, .tx_pair_data, .media_pair_lines, .short_gap_seen,
  .gap_link_drop, .global_irq);

// >>> dv/cu_pcs_model.sv
// copper-side stand-in: holds a fault level a few cycles, flips line states
`timescale 1ns/1ns
module cu_pcs_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic fire,
  input wire logic [4:0] sel,
  output logic [9:0] ev,
  output logic [6:0] st
);
  logic [2:0] hold_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hold_q <= 3'h0;
      ev <= 10'h000;
      st <= 7'h00;
    end else if (fire && sel < 5'ha) begin
      hold_q <= 3'h4;
      ev <= 10'h001 << sel;
    end else if (fire) begin
      st <= st ^ (7'h01 << (sel - 5'ha));
    end else if (hold_q != 3'h0) begin
      hold_q <= hold_q - 3'h1;
    end else begin
      ev <= 10'h000;
    end
  end
endmodule : cu_pcs_model

// >>> dv/test_copper_event_status_and_tx_polarity.sv
// self-checking bench: register access, event latching, line controls
`timescale 1ns/1ns
module test_copper_event_status_and_tx_polarity import cu_event_pkg::*;;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [31:0] wdat = 32'h0;
  logic [3:0] tx = 4'h0;
  logic gap = 1'b0;
  logic slow = 1'b0;
  logic fire = 1'b0;
  logic [4:0] sel = 5'h00;
  logic [3:0] bsel = 4'hf;
  logic [3:0] lanes = 4'hf;
  logic [31:0] rdat, q;
  logic ack, err, drop, irq, e;
  logic [3:0] pairs;
  logic [9:0] ev;
  logic [6:0] st;
  logic [15:0] ctrl;
  int n_errors = 0;
  int n_compared = 0;
  int seed = 32'h0f85;
  initial forever #50 sys_clk = ~sys_clk;
  cu_pcs_model i_pcs (.sys_clk(sys_clk), .rst(rst), .fire(fire), .sel(sel), .ev(ev), .st(st));
  cu_event_status i_dut (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(bsel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .wb_err_o(err), .speed(st[1:0]), .full_duplex(st[2]), .link_up(st[3]),
    .crossed_pairs(st[4]), .energy_sleep(st[5]), .rx_polarity_reversed(st[6]),
    .ms_resolve_fail(ev[0]), .parallel_detect_fault(ev[1]), .no_highest_common_ability(ev[2]),
    .an_done_no_link(ev[3]), .page_received(ev[4]), .an_complete(ev[5]),
    .symbol_error(ev[6]), .false_carrier(ev[7]), .flp_done_no_link(ev[8]), .jabber(ev[9]),
    .short_gap_seen(gap), .low_speed_mode(slow), .tx_pair_data(tx),
    .media_pair_lines(pairs), .gap_link_drop(drop), .global_irq(irq));
  task automatic finish_test;
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check
  // holds the request until ack or err is sampled, then releases
  task automatic wb(input logic w, input logic [7:0] idx, input logic [15:0] d);
    int k;
    k = 0;
    @(posedge sys_clk);
    cyc <= 1'b1;
    we <= w;
    bsel <= lanes;
    adr <= {idx, 2'b00};
    wdat <= {16'h0000, d};
    do begin
      @(posedge sys_clk);
      k++;
    end while (ack !== 1'b1 && err !== 1'b1 && k < 20);
    q = rdat;
    e = err;
    cyc <= 1'b0;
    if (ack !== 1'b1 && err !== 1'b1) begin
      n_errors++;
      finish_test;
    end
  endtask : wb
  task automatic rd(input logic [7:0] idx, input logic [15:0] exp);
    wb(1'b0, idx, 16'h0000);
    check(q, {16'h0000, exp});
  endtask : rd
  // event level ends inside the wait, so the first read sees only the latched bit
  task automatic hit(input int s);
    @(posedge sys_clk);
    fire <= 1'b1;
    sel <= 5'(s);
    @(posedge sys_clk);
    fire <= 1'b0;
    repeat (10) @(posedge sys_clk);
  endtask : hit
  function automatic logic [15:0] ev_mask(input int s);
    case (s)
      0, 1, 2, 3: return 16'h8000;
      4: return 16'h1000;
      5: return 16'h0800;
      6: return 16'h0200;
      7: return 16'h0100;
      8: return 16'h0008;
      9: return 16'h0001;
      10, 11: return 16'h4000;
      12: return 16'h2000;
      13: return 16'h0400;
      14: return 16'h0040;
      15: return 16'h0010;
      default: return 16'h0002;
    endcase
  endfunction : ev_mask
  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    rd(line_ctrl_idx, line_ctrl_reset);
    rd(event_latch_idx, event_latch_reset);
    for (int s = 0; s < 17; s++) begin
      hit(s);
      rd(event_latch_idx, ev_mask(s));
      rd(event_latch_idx, 16'h0000);
    end
    wb(1'b0, 8'h3c, 16'h0000);
    check({31'h0, e}, 32'h1);
    for (int i = 0; i < 6; i++) begin
      // keep bit walks all four mixes with the speed mode below
      ctrl = 16'(($random(seed) & 32'h000f) | 32'h0020 | (i[1] ? 32'h0040 : 32'h0));
      wb(1'b1, line_ctrl_idx, ctrl);
      rd(line_ctrl_idx, ctrl);
      tx <= 4'($random(seed));
      gap <= 1'b1;
      slow <= i[0];
      repeat (5) @(posedge sys_clk);
      check({28'h0, pairs}, {28'h0, tx ^ ctrl[3:0]});
      check({31'h0, drop}, {31'h0, i[0] & ~ctrl[6]});
      gap <= 1'b0;
    end
    // low lane off: the control write must leave every bit alone
    lanes = 4'he;
    wb(1'b1, line_ctrl_idx, ctrl ^ 16'h004f);
    lanes = 4'hf;
    rd(line_ctrl_idx, ctrl);
    wb(1'b1, irq_enable_idx, irq_enable_used);
    hit(9);
    check({31'h0, irq}, 32'h1);
    rd(global_irq_idx, 16'h0001);
    rd(event_latch_idx, 16'h0001);
    repeat (2) @(posedge sys_clk);
    check({31'h0, irq}, 32'h0);
    wb(1'b1, irq_enable_idx, 16'h0000);
    hit(9);
    check({31'h0, irq}, 32'h0);
    wb(1'b1, sw_reset_idx, 16'h0001);
    repeat (2) @(posedge sys_clk);
    rd(event_latch_idx, 16'h0000);
    rd(line_ctrl_idx, ctrl);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rd(line_ctrl_idx, line_ctrl_reset);
    finish_test;
  end
endmodule : test_copper_event_status_and_tx_polarity

// >>> src/change_detect.sv
// level-change detector: one pulse whenever a tracked level moves once armed after a reset
`timescale 1ns/1ns
module change_detect #(
  parameter int width = 1
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic soft_rst,
  input wire logic [width-1:0] level,
  output logic [width-1:0] changed
);
  logic [width-1:0] seen_q;
  logic [width-1:0] seen_d;
  logic [2:0] arm_q;
  logic [2:0] arm_d;

  // blind until the synchroniser has passed real levels through, else a pin
  // sitting high at reset would look like a change; events in the window are lost
  always_comb begin
    seen_d = level;
    arm_d = soft_rst ? 3'b000 : {arm_q[1:0], 1'b1};
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      seen_q <= '0;
      arm_q <= 3'b000;
    end else begin
      seen_q <= seen_d;
      arm_q <= arm_d;
    end
  end

  assign changed = arm_q[2] ? (seen_q ^ level) : '0;
endmodule : change_detect

// >>> src/cu_event_pkg.sv
// register map, field positions and reset values of the copper event block
package cu_event_pkg;
  // register indices, not byte offsets: byte address is index times four
  localparam logic [7:0] event_latch_idx = 8'h13;
  localparam logic [7:0] line_ctrl_idx = 8'h14;
  localparam logic [7:0] irq_enable_idx = 8'h12;
  localparam logic [7:0] global_irq_idx = 8'h17;
  localparam logic [7:0] sw_reset_idx = 8'h18;
  localparam int an_error_bit = 15;
  localparam int speed_chg_bit = 14;
  localparam int duplex_chg_bit = 13;
  localparam int page_rx_bit = 12;
  localparam int an_done_bit = 11;
  localparam int link_chg_bit = 10;
  localparam int symbol_err_bit = 9;
  localparam int false_carrier_bit = 8;
  localparam int xover_chg_bit = 6;
  localparam int energy_chg_bit = 4;
  localparam int flp_no_link_bit = 3;
  localparam int polarity_chg_bit = 1;
  localparam int jabber_bit = 0;
  localparam int gap_keep_bit = 6;
  localparam int reserved_one_bit = 5;
  localparam logic [15:0] line_ctrl_reset = 16'h0020;
  localparam logic [15:0] line_ctrl_writable = 16'h00df;
  localparam logic [15:0] event_latch_used = 16'hff5b;
  localparam logic [15:0] irq_enable_reset = 16'h0000;
  localparam logic [15:0] irq_enable_used = 16'hff5b;
  localparam logic [15:0] event_latch_reset = 16'h0000;
endpackage : cu_event_pkg

// >>> src/cu_event_status.sv
// copper event latch, line control register and wishbone slave
// Functional notes
// RULE1: negotiation error latches on failed master/slave, parallel-detect fault, no common ability or no link after negotiation.
// RULE2: a change of resolved speed sets the speed-change bit, which otherwise reads zero.
// RULE3: a change of resolved duplex sets the duplex-change bit, which otherwise reads zero.
// RULE4: a page arriving from the partner sets the page-received bit.
// RULE5: completion of auto-negotiation sets the negotiation-complete bit.
// RULE6: link going up or down sets the link-change bit.
// RULE7: symbol errors and false carrier each set their own bit.
// RULE8: a change of straight or crossed pair assignment sets the crossover-change bit.
// RULE9: energy detect moving between sleep and active sets the energy-change bit.
// RULE10: fast link pulse exchange finishing without link sets its bit.
// RULE11: receive polarity changes and jabber each set their own bit.
// RULE12: with the gap control bit zero the link drops on short gaps at 10 and 100 Mb/s, with one it is kept.
// RULE13: each of four pair control bits inverts that pair's transmit polarity when one.
// RULE14: software writes only reset values into reserved control fields.
// RULE15: a global flag reads one while any enabled event is pending.
// RULE16: latched bits hold until read, a read clears them unless the event persists, resets clear them.
// RULE17: control fields survive a software reset except the reserved bit that resets to one.
`timescale 1ns/1ns
module cu_event_status
  import cu_event_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // resolved state from the copper pcs, pins: synchronised here
  input wire logic [1:0] speed,
  input wire logic full_duplex,
  input wire logic link_up,
  input wire logic crossed_pairs,
  input wire logic energy_sleep,
  input wire logic rx_polarity_reversed,
  // event strobes from the pcs, pins: synchronised here, level per event
  input wire logic ms_resolve_fail,
  input wire logic parallel_detect_fault,
  input wire logic no_highest_common_ability,
  input wire logic an_done_no_link,
  input wire logic page_received,
  input wire logic an_complete,
  input wire logic symbol_error,
  input wire logic false_carrier,
  input wire logic flp_done_no_link,
  input wire logic jabber,
  // line side
  input wire logic short_gap_seen,
  input wire logic low_speed_mode,
  input wire logic [3:0] tx_pair_data,
  output logic [3:0] media_pair_lines,
  output logic gap_link_drop,
  output logic global_irq
);
  localparam int n_state = 8;
  localparam int n_event = 10;

  logic [n_state-1:0] state_s;
  logic [n_event-1:0] event_s;
  logic [n_state-1:0] state_chg;
  logic gap_s;
  logic slow_s;
  logic soft_rst;

  sync2 #(.width(n_state + n_event + 2)) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in({speed, full_duplex, link_up, crossed_pairs, energy_sleep,
      rx_polarity_reversed, 1'b0, ms_resolve_fail, parallel_detect_fault,
      no_highest_common_ability, an_done_no_link, page_received, an_complete,
      symbol_error, false_carrier, flp_done_no_link, jabber, short_gap_seen,
      low_speed_mode}),
    .sync_out({state_s, event_s, gap_s, slow_s})
  );

  change_detect #(.width(n_state)) u_chg (
    .sys_clk(sys_clk),
    .rst(rst),
    .soft_rst(soft_rst),
    .level(state_s),
    .changed(state_chg)
  );

  // whether an access hits a given register index; used for decode of reads and writes
  function automatic logic hit(input logic [9:0] adr, input logic [7:0] idx);
    hit = (adr[9:2] == idx) && (adr[1:0] == 2'b00);
  endfunction : hit

  logic [15:0] raw_event;
  logic [15:0] latch_q;
  logic [15:0] latch_d;
  logic [15:0] ctrl_q;
  logic [15:0] ctrl_d;
  logic [15:0] enable_q;
  logic [15:0] enable_d;
  logic ack_q;
  logic ack_d;
  logic err_q;
  logic err_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic soft_q;
  logic soft_d;
  logic req;
  logic mapped;
  logic rd_latch;

  always_comb begin
    raw_event = '0;
    raw_event[an_error_bit] = |event_s[9:6]; // see RULE1
    raw_event[speed_chg_bit] = |state_chg[7:6]; // see RULE2
    raw_event[duplex_chg_bit] = state_chg[5]; // see RULE3
    raw_event[page_rx_bit] = event_s[5]; // see RULE4
    raw_event[an_done_bit] = event_s[4]; // see RULE5
    raw_event[link_chg_bit] = state_chg[4]; // see RULE6
    raw_event[symbol_err_bit] = event_s[3]; // see RULE7
    raw_event[false_carrier_bit] = event_s[2]; // see RULE7
    raw_event[xover_chg_bit] = state_chg[3]; // see RULE8
    raw_event[energy_chg_bit] = state_chg[2]; // see RULE9
    raw_event[flp_no_link_bit] = event_s[1]; // see RULE10
    raw_event[polarity_chg_bit] = state_chg[1]; // see RULE11
    raw_event[jabber_bit] = event_s[0]; // see RULE11
  end

  // one wait state: ack comes one edge after the request is seen
  assign req = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
  assign mapped = hit(wb_adr_i, event_latch_idx) || hit(wb_adr_i, line_ctrl_idx) ||
    hit(wb_adr_i, irq_enable_idx) || hit(wb_adr_i, global_irq_idx) ||
    hit(wb_adr_i, sw_reset_idx);
  assign rd_latch = req && !wb_we_i && hit(wb_adr_i, event_latch_idx);

  always_comb begin
    ack_d = req && mapped;
    err_d = req && !mapped;
    rdata_d = rdata_q;
    soft_d = 1'b0;
    // set wins over a clearing read in the same cycle
    latch_d = ((rd_latch ? 16'h0000 : latch_q) | raw_event) & event_latch_used; // see RULE16
    ctrl_d = ctrl_q;
    enable_d = enable_q;
    // an unmapped read answers err and leaves the read data as it was
    if (req && !wb_we_i && mapped) begin
      rdata_d = 32'h0000_0000;
      if (hit(wb_adr_i, event_latch_idx)) rdata_d[15:0] = latch_q;
      if (hit(wb_adr_i, line_ctrl_idx)) rdata_d[15:0] = ctrl_q;
      if (hit(wb_adr_i, irq_enable_idx)) rdata_d[15:0] = enable_q;
      if (hit(wb_adr_i, global_irq_idx)) rdata_d[0] = global_irq;
    end
    if (req && wb_we_i) begin
      if (hit(wb_adr_i, line_ctrl_idx)) begin
        // reserved fields are kept at reset value whatever is written
        if (wb_sel_i[0]) ctrl_d = (wb_dat_i[15:0] & line_ctrl_writable) | line_ctrl_reset; // see RULE14
      end
      if (hit(wb_adr_i, irq_enable_idx)) begin
        if (wb_sel_i[0]) enable_d[7:0] = wb_dat_i[7:0] & irq_enable_used[7:0];
        if (wb_sel_i[1]) enable_d[15:8] = wb_dat_i[15:8] & irq_enable_used[15:8];
      end
      if (hit(wb_adr_i, sw_reset_idx) && wb_sel_i[0] && wb_dat_i[0]) soft_d = 1'b1;
    end
    if (soft_q) begin
      latch_d = event_latch_reset; // see RULE16
      ctrl_d[reserved_one_bit] = 1'b1; // see RULE17
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      latch_q <= event_latch_reset;
      ctrl_q <= line_ctrl_reset;
      enable_q <= irq_enable_reset;
      ack_q <= 1'b0;
      err_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      soft_q <= 1'b0;
    end else begin
      latch_q <= latch_d;
      ctrl_q <= ctrl_d;
      enable_q <= enable_d;
      ack_q <= ack_d;
      err_q <= err_d;
      rdata_q <= rdata_d;
      soft_q <= soft_d;
    end
  end

  assign soft_rst = soft_q;
  assign wb_ack_o = ack_q;
  assign wb_err_o = err_q;
  assign wb_dat_o = rdata_q;

  logic [3:0] pair_q;
  logic [3:0] pair_d;
  logic drop_q;
  logic drop_d;
  logic irq_q;
  logic irq_d;

  always_comb begin
    pair_d = tx_pair_data ^ ctrl_q[3:0]; // see RULE13
    // gigabit never breaks on gaps, and a set keep bit overrides
    drop_d = gap_s && slow_s && !ctrl_q[gap_keep_bit]; // see RULE12
    irq_d = |(latch_q & enable_q); // see RULE15
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pair_q <= 4'h0;
      drop_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      pair_q <= pair_d;
      drop_q <= drop_d;
      irq_q <= irq_d;
    end
  end

  assign media_pair_lines = pair_q;
  assign gap_link_drop = drop_q;
  assign global_irq = irq_q;
endmodule : cu_event_status

// >>> src/sync2.sv
// two-flop synchroniser for pin levels
`timescale 1ns/1ns
module sync2 #(
  parameter int width = 1
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [width-1:0] async_in,
  output logic [width-1:0] sync_out
);
  logic [width-1:0] meta_q;
  logic [width-1:0] sync_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule : sync2
